/* design/mpsp_defines.svh */
// register offsets, field positions and reset values
`ifndef MPSP_DEFINES_SVH
`define MPSP_DEFINES_SVH
// register offsets
`define MPSP_ADDR_CTRL   4'h0
`define MPSP_ADDR_STAT   4'h1
`define MPSP_ADDR_TXD    4'h2
`define MPSP_ADDR_RXD    4'h3
`define MPSP_ADDR_PORT   4'h4
`define MPSP_ADDR_BAUD   4'h5
`define MPSP_ADDR_PIN    4'h6
// control register fields
`define MPSP_C_TE        0
`define MPSP_C_RE        1
`define MPSP_C_TIE       2
`define MPSP_C_RIE       3
`define MPSP_C_TX_END_IRQ_ENABLE      4
`define MPSP_C_ID_WAIT_ENABLE      5
`define MPSP_C_PAR_EN    6
`define MPSP_C_PAR_ODD   7
// status register fields
`define MPSP_S_TXE       7
`define MPSP_S_RXF       6
`define MPSP_S_OVR       5
`define MPSP_S_FRM       4
`define MPSP_S_PAR       3
`define MPSP_S_TX_END_FLAG      2
`define MPSP_S_MPB       1
`define MPSP_S_MP_MARKER_TX_BIT      0
// port register fields
`define MPSP_P_DIR       0
`define MPSP_P_DAT       1
// reset values
`define MPSP_CTRL_RST    8'h00
`define MPSP_BAUD_RST    16'h0363
`define MPSP_BYTE_ZERO   8'h00
`define MPSP_CNT_ZERO    16'h0000
`define MPSP_BIT_ZERO    4'h0
`endif

/* design/mpsp_pkg.sv */
// types shared by the serial port design files
package mpsp_pkg;
   typedef enum logic [1:0] {
      MPSP_TX_IDLE = 2'b00,
      MPSP_TX_SEND = 2'b01,
      MPSP_TX_STOP = 2'b11
   } mpsp_tx_state_t;
   typedef enum logic [1:0] {
      MPSP_RX_IDLE = 2'b00,
      MPSP_RX_DATA = 2'b01,
      MPSP_RX_STOP = 2'b11
   } mpsp_rx_state_t;
endpackage

/* design/mpsp_rx_unit.sv */
// serial receive shift unit: mid-bit sampling, frame done pulse
`timescale 1ns/1ps
`default_nettype none
`include "mpsp_defines.svh"
module mpsp_rx_unit (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // control
   input wire logic enable,
   input wire logic [15:0] bit_div,
   input wire logic extra_en,
   // line
   input wire logic line_in,
   // result
   output logic done,
   output logic [7:0] data,
   output logic extra_bit,
   output logic stop_ok
);
   import mpsp_pkg::*;
   mpsp_rx_state_t st_reg, st_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [3:0] idx_reg, idx_next;
   logic [8:0] sh_reg, sh_next;
   logic done_reg, done_next;
   logic stop_reg, stop_next;
   logic tick;
   logic [3:0] last_idx;

   assign tick = (cnt_reg == bit_div);
   assign last_idx = extra_en ? 4'h9 : 4'h8;
   assign done = done_reg;
   assign data = sh_reg[7:0];
   assign extra_bit = sh_reg[8];
   assign stop_ok = stop_reg;

   // next state: start found, half bit to centre, then full bits
   always_comb begin
      st_next = st_reg;
      cnt_next = tick ? `MPSP_CNT_ZERO : cnt_reg + 16'h0001;
      idx_next = idx_reg;
      sh_next = sh_reg;
      done_next = 1'b0;
      stop_next = stop_reg;
      case (st_reg)
         MPSP_RX_IDLE: begin
            cnt_next = {1'b0, bit_div[15:1]};
            idx_next = `MPSP_BIT_ZERO;
            if (!line_in) begin
               st_next = MPSP_RX_DATA;
            end
         end
         MPSP_RX_DATA: begin
            if (tick) begin
               if (idx_reg != `MPSP_BIT_ZERO) begin
                  sh_next[idx_reg - 4'h1] = line_in;
               end
               if (idx_reg == last_idx) begin
                  st_next = MPSP_RX_STOP;
               end else begin
                  idx_next = idx_reg + 4'h1;
               end
            end
         end
         MPSP_RX_STOP: begin
            if (tick) begin
               stop_next = line_in;
               done_next = 1'b1;
               st_next = MPSP_RX_IDLE;
            end
         end
         default: st_next = MPSP_RX_IDLE;
      endcase
      if (!extra_en) begin
         sh_next[8] = 1'b0;
      end
      if (!enable) begin
         st_next = MPSP_RX_IDLE;
         done_next = 1'b0;
      end
   end

   // register stage
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= MPSP_RX_IDLE;
         cnt_reg <= `MPSP_CNT_ZERO;
         idx_reg <= `MPSP_BIT_ZERO;
         sh_reg <= 9'h000;
         done_reg <= 1'b0;
         stop_reg <= 1'b1;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         idx_reg <= idx_next;
         sh_reg <= sh_next;
         done_reg <= done_next;
         stop_reg <= stop_next;
      end
   end
endmodule
`default_nettype wire

/* design/mpsp_serial_unit.sv */
// multiprocessor asynchronous serial port: registers, flags, requests
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "mpsp_defines.svh"
module mpsp_serial_unit (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // serial pins
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_oe,
   // interrupt requests
   output logic tx_empty_irq,
   output logic tx_end_irq,
   output logic rx_full_irq,
   output logic rx_error_irq
);
   import mpsp_pkg::*;

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   // configuration written by software
   logic [7:0] serial_control_reg;
   logic [7:0] serial_control_next;
   logic [15:0] baud_reg;
   logic [15:0] baud_next;
   logic [1:0] port_reg;
   logic [1:0] port_next;

   // data holding registers and the registered read port
   logic [7:0] tx_holding_reg;
   logic [7:0] tx_holding_next;
   logic [7:0] rx_holding_reg;
   logic [7:0] rx_holding_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   // status flags; hardware sets them except the transmit marker bit, which software writes; software or the units clear them
   logic tx_empty_flag_reg;
   logic tx_empty_flag_next;
   logic tx_end_flag_reg;
   logic tx_end_flag_next;
   logic rx_full_flag_reg;
   logic rx_full_flag_next;
   logic overrun_flag_reg;
   logic overrun_flag_next;
   logic framing_flag_reg;
   logic framing_flag_next;
   logic parity_err_flag_reg;
   logic parity_err_flag_next;
   logic mp_marker_tx_bit_reg;
   logic mp_marker_tx_bit_next;
   logic mp_marker_rx_bit_reg;
   logic mp_marker_rx_bit_next;

   // control fields
   logic transmit_enable;
   logic receive_enable;
   logic tx_irq_enable;
   logic rx_irq_enable;
   logic tx_end_irq_enable;
   logic id_wait_enable;
   logic parity_en;
   logic parity_odd;
   logic extra_en;
   assign transmit_enable = serial_control_reg[`MPSP_C_TE];
   assign receive_enable = serial_control_reg[`MPSP_C_RE];
   assign tx_irq_enable = serial_control_reg[`MPSP_C_TIE];
   assign rx_irq_enable = serial_control_reg[`MPSP_C_RIE];
   assign tx_end_irq_enable = serial_control_reg[`MPSP_C_TX_END_IRQ_ENABLE];
   assign id_wait_enable = serial_control_reg[`MPSP_C_ID_WAIT_ENABLE];
   assign parity_en = serial_control_reg[`MPSP_C_PAR_EN];
   assign parity_odd = serial_control_reg[`MPSP_C_PAR_ODD];

   // parity overrides the marker bit format; the ninth bit is marker or parity
   assign extra_en = 1'b1;

   // access decode
   logic wr_ctrl;
   logic wr_stat;
   logic wr_txd;
   logic wr_port;
   logic wr_baud;
   logic rd_rxd;
   assign wr_ctrl = reg_wr && (reg_addr == `MPSP_ADDR_CTRL);
   assign wr_stat = reg_wr && (reg_addr == `MPSP_ADDR_STAT);
   assign wr_txd = reg_wr && (reg_addr == `MPSP_ADDR_TXD);
   assign wr_port = reg_wr && (reg_addr == `MPSP_ADDR_PORT);
   assign wr_baud = reg_wr && (reg_addr == `MPSP_ADDR_BAUD);
   assign rd_rxd = reg_rd && (reg_addr == `MPSP_ADDR_RXD);

   // ----------------------------------------------------------------
   // shift units
   // ----------------------------------------------------------------
   // transmit unit handshake and line
   logic tx_take;
   logic tx_stop_done;
   logic tx_line;
   // receive unit results and run gate
   logic rx_done;
   logic rx_extra;
   logic rx_stop_ok;
   logic [7:0] rx_data;
   logic rx_run;

   // shared by the transmit ninth bit and the receive check
   // parity of a data byte, odd or even sense
   function automatic logic par_bit(input logic [7:0] d, input logic odd);
      par_bit = (^d) ^ odd;
   endfunction

   // the ninth bit is the marker when parity is off
   logic tx_ninth;
   assign tx_ninth = parity_en ? par_bit(tx_holding_reg, parity_odd) : mp_marker_tx_bit_reg;

   mpsp_tx_unit u_tx (
      .mclk(mclk),
      .rst_b(rst_b),
      .enable(transmit_enable),
      .bit_div(baud_reg),
      .extra_en(extra_en),
      .load_valid(!tx_empty_flag_reg),
      .load_frame({tx_ninth, tx_holding_reg}),
      .load_take(tx_take),
      .stop_done(tx_stop_done),
      .line_out(tx_line)
   );

   // reception halts while overrun or framing error stands
   assign rx_run = receive_enable && !overrun_flag_reg && !framing_flag_reg;

   mpsp_rx_unit u_rx (
      .mclk(mclk),
      .rst_b(rst_b),
      .enable(rx_run),
      .bit_div(baud_reg),
      .extra_en(extra_en),
      .line_in(serial_in_pin),
      .done(rx_done),
      .data(rx_data),
      .extra_bit(rx_extra),
      .stop_ok(rx_stop_ok)
   );

   // ----------------------------------------------------------------
   // flags and registers
   // ----------------------------------------------------------------
   // per-frame verdicts of the receiver
   logic frm_err;
   logic par_err;
   logic id_frame;
   logic drop_frame;
   logic accept;
   assign frm_err = !rx_stop_ok;
   assign par_err = parity_en && (rx_extra != par_bit(rx_data, parity_odd));
   assign id_frame = !parity_en && rx_extra;
   assign drop_frame = id_wait_enable && !parity_en && !rx_extra;
   assign accept = rx_done && !drop_frame;

   // next values of all register state except the read data
   always_comb begin
      serial_control_next = wr_ctrl ? reg_wdata : serial_control_reg;
      baud_next = baud_reg;
      port_next = wr_port ? reg_wdata[1:0] : port_reg;
      tx_holding_next = tx_holding_reg;
      rx_holding_next = rx_holding_reg;
      tx_empty_flag_next = tx_empty_flag_reg;
      tx_end_flag_next = tx_end_flag_reg;
      rx_full_flag_next = rx_full_flag_reg;
      overrun_flag_next = overrun_flag_reg;
      framing_flag_next = framing_flag_reg;
      parity_err_flag_next = parity_err_flag_reg;
      mp_marker_tx_bit_next = mp_marker_tx_bit_reg;
      mp_marker_rx_bit_next = mp_marker_rx_bit_reg;
      // divisor takes the high byte first, each write shifts it up
      if (wr_baud) begin
         baud_next = {baud_reg[7:0], reg_wdata};
      end
      // software clears error flags by writing zero; marker bit is plain
      if (wr_stat) begin
         if (!reg_wdata[`MPSP_S_OVR]) overrun_flag_next = 1'b0;
         if (!reg_wdata[`MPSP_S_FRM]) framing_flag_next = 1'b0;
         if (!reg_wdata[`MPSP_S_PAR]) parity_err_flag_next = 1'b0;
         if (!reg_wdata[`MPSP_S_RXF]) rx_full_flag_next = 1'b0;
         mp_marker_tx_bit_next = reg_wdata[`MPSP_S_MP_MARKER_TX_BIT];
      end

      // transmit side
      if (tx_take) begin
         tx_empty_flag_next = 1'b1;
         tx_end_flag_next = 1'b0;
      end
      if (tx_stop_done && tx_empty_flag_reg) begin
         tx_end_flag_next = 1'b1;
      end
      if (wr_txd) begin
         tx_holding_next = reg_wdata;
         tx_empty_flag_next = 1'b0;
      end
      // clearing transmit enable reinitialises the transmit flags
      if (!transmit_enable) begin
         tx_empty_flag_next = !wr_txd;
         tx_end_flag_next = 1'b1;
      end

      // receive events are applied after software clears, so a set wins
      // receive side: read clears full, new frame sets over it
      if (rd_rxd) begin
         rx_full_flag_next = 1'b0;
      end
      if (accept) begin
         if (rx_full_flag_reg) begin
            overrun_flag_next = 1'b1;
         end else begin
            rx_holding_next = rx_data;
            mp_marker_rx_bit_next = rx_extra;
            if (!frm_err && !par_err) begin
               rx_full_flag_next = 1'b1;
            end
         end
         if (frm_err) framing_flag_next = 1'b1;
         if (par_err) parity_err_flag_next = 1'b1;
      end
      // an id frame ends the wait for an id
      if (rx_done && id_wait_enable && id_frame) begin
         serial_control_next[`MPSP_C_ID_WAIT_ENABLE] = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   // read data, valid in the cycle after the read strobe
   always_comb begin
      rdata_next = `MPSP_BYTE_ZERO;
      if (reg_rd) begin
         case (reg_addr)
            `MPSP_ADDR_CTRL: rdata_next = serial_control_reg;
            `MPSP_ADDR_STAT: begin
               rdata_next = {tx_empty_flag_reg, rx_full_flag_reg,
                  overrun_flag_reg, framing_flag_reg,
                  parity_err_flag_reg, tx_end_flag_reg,
                  mp_marker_rx_bit_reg, mp_marker_tx_bit_reg};
            end
            `MPSP_ADDR_TXD: rdata_next = tx_holding_reg;
            `MPSP_ADDR_RXD: rdata_next = rx_holding_reg;
            `MPSP_ADDR_PORT: rdata_next = {6'h00, port_reg};
            `MPSP_ADDR_BAUD: rdata_next = baud_reg[7:0];
            `MPSP_ADDR_PIN: rdata_next = {7'h00, serial_in_pin};
            default: rdata_next = `MPSP_BYTE_ZERO;
         endcase
      end
   end

   // register stage; transmit flags come up set
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         serial_control_reg <= `MPSP_CTRL_RST;
         baud_reg <= `MPSP_BAUD_RST;
         port_reg <= 2'h0;
         tx_holding_reg <= `MPSP_BYTE_ZERO;
         rx_holding_reg <= `MPSP_BYTE_ZERO;
         rdata_reg <= `MPSP_BYTE_ZERO;
         tx_empty_flag_reg <= 1'b1;
         tx_end_flag_reg <= 1'b1;
         rx_full_flag_reg <= 1'b0;
         overrun_flag_reg <= 1'b0;
         framing_flag_reg <= 1'b0;
         parity_err_flag_reg <= 1'b0;
         mp_marker_tx_bit_reg <= 1'b0;
         mp_marker_rx_bit_reg <= 1'b0;
      end else begin
         serial_control_reg <= serial_control_next;
         baud_reg <= baud_next;
         port_reg <= port_next;
         tx_holding_reg <= tx_holding_next;
         rx_holding_reg <= rx_holding_next;
         rdata_reg <= rdata_next;
         tx_empty_flag_reg <= tx_empty_flag_next;
         tx_end_flag_reg <= tx_end_flag_next;
         rx_full_flag_reg <= rx_full_flag_next;
         overrun_flag_reg <= overrun_flag_next;
         framing_flag_reg <= framing_flag_next;
         parity_err_flag_reg <= parity_err_flag_next;
         mp_marker_tx_bit_reg <= mp_marker_tx_bit_next;
         mp_marker_rx_bit_reg <= mp_marker_rx_bit_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata = rdata_reg;

   // disabled transmitter hands the pin to the port registers
   // the pin stays driven while the port direction is output
   assign serial_out_pin = transmit_enable ? tx_line : port_reg[`MPSP_P_DAT];
   assign serial_out_oe = transmit_enable || port_reg[`MPSP_P_DIR];

   // four requests, one vector, six causes
   // tx empty request also needs the transmitter enabled
   assign tx_empty_irq = tx_irq_enable && transmit_enable
      && tx_empty_flag_reg;
   // tx end request follows its flag and enable alone
   assign tx_end_irq = tx_end_irq_enable && tx_end_flag_reg;
   // both receive requests are gated by the receive enable
   assign rx_full_irq = rx_irq_enable && receive_enable && rx_full_flag_reg;
   assign rx_error_irq = rx_irq_enable && receive_enable
      && (overrun_flag_reg || framing_flag_reg || parity_err_flag_reg);
endmodule
`default_nettype wire

/* design/mpsp_tx_unit.sv */
// serial transmit shift unit: start, eight data, marker or parity, stop
`timescale 1ns/1ps
`default_nettype none
`include "mpsp_defines.svh"
module mpsp_tx_unit (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // control
   input wire logic enable,
   input wire logic [15:0] bit_div,
   input wire logic extra_en,
   // load handshake
   input wire logic load_valid,
   input wire logic [8:0] load_frame,
   output logic load_take,
   // status and line
   output logic stop_done,
   output logic line_out
);
   import mpsp_pkg::*;
   mpsp_tx_state_t st_reg, st_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [3:0] idx_reg, idx_next;
   logic [9:0] sh_reg, sh_next;
   logic line_reg, line_next;
   logic tick;
   logic [3:0] last_idx;

   // bit tick and frame length
   assign tick = (cnt_reg == bit_div);
   assign last_idx = extra_en ? 4'h9 : 4'h8;
   assign line_out = line_reg;

   // next state of the shifter; disable resets it at once
   always_comb begin
      st_next = st_reg;
      cnt_next = tick ? `MPSP_CNT_ZERO : cnt_reg + 16'h0001;
      idx_next = idx_reg;
      sh_next = sh_reg;
      line_next = line_reg;
      load_take = 1'b0;
      stop_done = 1'b0;
      case (st_reg)
         MPSP_TX_IDLE: begin
            cnt_next = `MPSP_CNT_ZERO;
            line_next = 1'b1;
            if (load_valid) begin
               load_take = 1'b1;
               sh_next = {1'b0, load_frame};
               line_next = 1'b0;
               idx_next = `MPSP_BIT_ZERO;
               st_next = MPSP_TX_SEND;
            end
         end
         MPSP_TX_SEND: begin
            if (tick) begin
               if (idx_reg == last_idx) begin
                  line_next = 1'b1;
                  st_next = MPSP_TX_STOP;
               end else begin
                  line_next = sh_reg[idx_reg];
                  idx_next = idx_reg + 4'h1;
               end
            end
         end
         MPSP_TX_STOP: begin
            if (tick) begin
               stop_done = 1'b1;
               // next frame follows the stop bit directly
               if (load_valid) begin
                  load_take = 1'b1;
                  sh_next = {1'b0, load_frame};
                  line_next = 1'b0;
                  idx_next = `MPSP_BIT_ZERO;
                  st_next = MPSP_TX_SEND;
               end else begin
                  st_next = MPSP_TX_IDLE;
               end
            end
         end
         default: st_next = MPSP_TX_IDLE;
      endcase
      if (!enable) begin
         st_next = MPSP_TX_IDLE;
         line_next = 1'b1;
         load_take = 1'b0;
         stop_done = 1'b0;
      end
   end

   // register stage
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= MPSP_TX_IDLE;
         cnt_reg <= `MPSP_CNT_ZERO;
         idx_reg <= `MPSP_BIT_ZERO;
         sh_reg <= 10'h3FF;
         line_reg <= 1'b1;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         idx_reg <= idx_next;
         sh_reg <= sh_next;
         line_reg <= line_next;
      end
   end
endmodule
`default_nettype wire

/* tb/mpsp_line_peer.sv */
// far-end station on the shared line: sends and captures frames
`timescale 1ns/1ps
`default_nettype none
module mpsp_line_peer #(parameter int BIT = 8) (
   // clock
   input wire logic mclk,
   // line
   input wire logic tx_line,
   output logic rx_line
);
   initial rx_line = 1'b1;
   // start, data lsb first, marker, stop; idle high after
   task automatic send(input logic [7:0] d, input logic mk, input logic sb);
      logic [10:0] f;
      f = {sb, mk, d, 1'b0};
      @(posedge mclk);
      for (int i = 0; i < 11; i++) begin
         rx_line <= f[i];
         repeat (BIT) @(posedge mclk);
      end
      rx_line <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask
   // hold the line low for n cycles
   task automatic brk(input int n);
      @(posedge mclk);
      rx_line <= 1'b0;
      repeat (n) @(posedge mclk);
      rx_line <= 1'b1;
   endtask
   // capture data, marker and stop at mid-bit
   task automatic grab(output logic [9:0] v);
      @(negedge tx_line);
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 10; i++) begin
         repeat (BIT) @(posedge mclk);
         v[i] = tx_line;
      end
   endtask
endmodule
`default_nettype wire

/* tb/mpsp_serial_unit_properties.sv */
// concurrent checks on the serial port register and pin behaviour
`timescale 1ns/1ps
`default_nettype none
`include "mpsp_defines.svh"
module mpsp_serial_unit_properties (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // line and requests
   input wire logic serial_out_pin,
   input wire logic tx_empty_irq,
   input wire logic tx_end_irq,
   input wire logic rx_full_irq,
   input wire logic rx_error_irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // control write followed by a read of the same register
   sequence s_ctrl_wr_rd;
      reg_wr && reg_addr == `MPSP_ADDR_CTRL ##2 reg_rd && reg_addr == `MPSP_ADDR_CTRL;
   endsequence
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside answer cycle");
   a_ctrl_readback: assert property (s_ctrl_wr_rd |=> reg_rdata == $past(reg_wdata, 3))
      else $error("control readback differs");
   a_unmapped_read: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_txd_clears_req: assert property (
      reg_wr && reg_addr == `MPSP_ADDR_TXD |=> !tx_empty_irq)
      else $error("tx empty request after data write");
   a_rxd_read_clears: assert property (
      reg_rd && reg_addr == `MPSP_ADDR_RXD |=> !rx_full_irq)
      else $error("rx full request after data read");
   a_err_clear_req: assert property (
      reg_wr && reg_addr == `MPSP_ADDR_STAT && reg_wdata[6:3] == 4'h0 |=> !rx_error_irq)
      else $error("error request after flag clear");
   // eight cycles per bit with the divisor the bench programs
   a_start_bit_len: assert property ($fell(serial_out_pin) |-> (!serial_out_pin)[*8])
      else $error("low level shorter than one bit");
   a_tx_end_flag_mark: assert property ($rose(tx_end_irq) |-> serial_out_pin)
      else $error("transmit end without mark level");
endmodule
bind mpsp_serial_unit mpsp_serial_unit_properties u_props (
   .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .serial_out_pin(serial_out_pin), .tx_empty_irq(tx_empty_irq),
   .tx_end_irq(tx_end_irq), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq)
);
`default_nettype wire

/* tb/multiproc_async_serial_port_tb.sv */
// self-checking bench for the multiprocessor serial port
`timescale 1ns/1ps
`default_nettype none
`include "mpsp_defines.svh"
module multiproc_async_serial_port_tb;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic line_in, line_out, line_oe, txe_irq, tx_end_flag_irq, rxf_irq, err_irq;
   int fail_count = 0;
   int n_checks = 0;
   int seed = 45;
   logic [7:0] rv, d0, d1;
   logic [9:0] fr;
   always #5 mclk = ~mclk;
   mpsp_serial_unit uut (
      .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .serial_in_pin(line_in), .serial_out_pin(line_out), .serial_out_oe(line_oe),
      .tx_empty_irq(txe_irq), .tx_end_irq(tx_end_flag_irq), .rx_full_irq(rxf_irq),
      .rx_error_irq(err_irq)
   );
   mpsp_line_peer #(.BIT(8)) peer (.mclk(mclk), .tx_line(line_out), .rx_line(line_in));
   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [9:0] frame_of(input logic [7:0] d, input logic mk);
      return {1'b1, mk, d};
   endfunction
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(negedge mclk);
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      rv = reg_rdata;
      chk(rv & m, e);
   endtask
   task automatic stop_test;
      if (fail_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // watchdog well beyond the expected run of about 1200 cycles
   initial begin
      #200000;
      fail_count++;
      stop_test;
   end
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      rc(`MPSP_ADDR_STAT, 8'hFF, 8'h84);
      rc(`MPSP_ADDR_PIN, 8'hFF, 8'h01);
      rc(4'hB, 8'hFF, 8'h00);
      wr(`MPSP_ADDR_BAUD, 8'h00);
      wr(`MPSP_ADDR_BAUD, 8'h07);
      wr(`MPSP_ADDR_CTRL, 8'h1F);
      rc(`MPSP_ADDR_CTRL, 8'hFF, 8'h1F);
      chk({txe_irq, tx_end_flag_irq, rxf_irq, err_irq}, 4'hC);
      // id frame, then a pending character overwritten before it moves
      fork
         begin
            peer.grab(fr);
            chk(fr, frame_of(d0, 1'b1));
            peer.grab(fr);
            chk(fr, frame_of(d1, 1'b0));
         end
         begin
            wr(`MPSP_ADDR_STAT, 8'h79);
            wr(`MPSP_ADDR_TXD, d0);
            rc(`MPSP_ADDR_STAT, 8'h80, 8'h80);
            wr(`MPSP_ADDR_STAT, 8'h78);
            wr(`MPSP_ADDR_TXD, ~d1);
            wr(`MPSP_ADDR_TXD, d1);
            chk(txe_irq, 1'b0);
         end
      join
      repeat (20) @(posedge mclk);
      chk({tx_end_flag_irq, line_out}, 2'b11);
      // good frame, then overrun
      peer.send(d0, 1'b0, 1'b1);
      chk(rxf_irq, 1'b1);
      peer.send(d1, 1'b0, 1'b1);
      chk({rxf_irq, err_irq}, 2'b11);
      rc(`MPSP_ADDR_STAT, 8'h78, 8'h60);
      rc(`MPSP_ADDR_RXD, 8'hFF, d0);
      chk(rxf_irq, 1'b0);
      wr(`MPSP_ADDR_STAT, 8'h00);
      // framing error keeps data, blocks further reception
      peer.send(d1, 1'b0, 1'b0);
      rc(`MPSP_ADDR_STAT, 8'h78, 8'h10);
      rc(`MPSP_ADDR_RXD, 8'hFF, d1);
      peer.send(8'h3C, 1'b0, 1'b1);
      rc(`MPSP_ADDR_STAT, 8'h40, 8'h00);
      wr(`MPSP_ADDR_STAT, 8'h00);
      // break on the input: flag returns after clearing
      fork
         peer.brk(240);
         begin
            repeat (120) @(posedge mclk);
            rc(`MPSP_ADDR_PIN, 8'hFF, 8'h00);
            rc(`MPSP_ADDR_STAT, 8'h10, 8'h10);
            wr(`MPSP_ADDR_STAT, 8'h00);
            repeat (100) @(posedge mclk);
            rc(`MPSP_ADDR_STAT, 8'h10, 8'h10);
            chk(err_irq, 1'b1);
         end
      join
      wr(`MPSP_ADDR_STAT, 8'h00);
      // id wait drops payload, takes the id frame
      wr(`MPSP_ADDR_CTRL, 8'h2B);
      peer.send(d0, 1'b0, 1'b1);
      chk(rxf_irq, 1'b0);
      peer.send(d1, 1'b1, 1'b1);
      rc(`MPSP_ADDR_CTRL, 8'h20, 8'h00);
      rc(`MPSP_ADDR_STAT, 8'h42, 8'h42);
      wr(`MPSP_ADDR_CTRL, 8'h29);
      chk(rxf_irq, 1'b0);
      rc(`MPSP_ADDR_RXD, 8'hFF, d1);
      // parity mode: a wrong ninth bit flags an error, data still lands
      wr(`MPSP_ADDR_CTRL, 8'h4B);
      peer.send(d0, ~^d0, 1'b1);
      rc(`MPSP_ADDR_STAT, 8'h78, 8'h08);
      rc(`MPSP_ADDR_RXD, 8'hFF, d0);
      chk(err_irq, 1'b1);
      wr(`MPSP_ADDR_STAT, 8'h00);
      // port takes the pin once transmit is off
      wr(`MPSP_ADDR_PORT, 8'h01);
      wr(`MPSP_ADDR_CTRL, 8'h00);
      chk({line_out, line_oe}, 2'b01);
      repeat (12) @(posedge mclk);
      wr(`MPSP_ADDR_PORT, 8'h03);
      chk({line_out, line_oe}, 2'b11);
      stop_test;
   end
endmodule
`default_nettype wire
